// File: hw/cgcp_pkg.sv
// shared types and constants of the clock generator control pins
package cgcp_pkg;
	// ==========================================================
	// sizes
	localparam int CGCP_N_OUT = 12;
	localparam int CGCP_N_IN = 4;
	localparam int CGCP_STAT_W = 4;
	localparam logic CGCP_IF_I2C = 1'b1;

	// ==========================================================
	// serial interface modes
	typedef enum logic [2:0] {
		CGCP_MODE_I2C = 3'b001,
		CGCP_MODE_SPI3 = 3'b010,
		CGCP_MODE_SPI4 = 3'b100
	} cgcp_mode_t;

	// ==========================================================
	// pin inputs that cross into the mclk domain
	typedef struct packed {
		logic if_sel;
		logic sdio;
		logic addr1;
		logic sclk;
		logic addr0_cs_n;
		logic low_power_n;
		logic hard_reset_n;
		logic out_dis;
		logic realign_n;
		logic [1:0] in_sel;
	} cgcp_pins_t;

	// values of the pull resistors, used as synchroniser reset
	localparam cgcp_pins_t CGCP_PINS_RST = '{
		if_sel: 1'b1, sdio: 1'b1, addr1: 1'b0, sclk: 1'b1, addr0_cs_n: 1'b1,
		low_power_n: 1'b1, hard_reset_n: 1'b1, out_dis: 1'b0, realign_n: 1'b1,
		in_sel: 2'h0
	};

	// serial pins as seen by the serial engine
	typedef struct packed {
		logic sclk;
		logic din;
		logic cs_n;
		logic [1:0] addr;
	} cgcp_ser_t;

	localparam cgcp_ser_t CGCP_SER_RST = '{
		sclk: 1'b1, din: 1'b1, cs_n: 1'b1, addr: 2'h0
	};

	// output pin with its enable
	typedef struct packed {
		logic out;
		logic oe;
	} cgcp_drv_t;

	localparam cgcp_drv_t CGCP_DRV_OFF = '{out: 1'b0, oe: 1'b0};
endpackage

// File: hw/cgcp_pins.sv
// control and status pin logic of the clock generator
// Notes on behaviour
// - interface-select pin high picks I2C, low picks SPI; floats high.
// - data pin: bidirectional in I2C and 3-wire SPI, input only in 4-wire.
// - second pin is address bit 1 in I2C, serial data out in 4-wire SPI.
// - host drives serial clock; all serial transfers follow it.
// - third pin is address bit 0 in I2C, active-low select in SPI.
// - open-drain interrupt pulls low when device status changes.
// - power-down input low puts device in low-power mode.
// - reset input low resets all logic and registers except the pin synchronisers to defaults.
// - all clock outputs disabled while reset is in progress.
// - output-disable high disables every clock output; floats low.
// - lock output high while locked, low while out of lock.
// - realign input low resets all output dividers.
// - in manual mode, input-select pins choose the active clock input.
`timescale 1ns/1ps
module cgcp_pins
	import cgcp_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// raw pins from outside
	input wire cgcp_pins_t pins_in,
	// serial data pin drive
	output cgcp_drv_t sdio_drv,
	// address 1 / serial data out pin drive
	output cgcp_drv_t addr1_sdo_drv,
	// open-drain interrupt pin drive
	output cgcp_drv_t status_change_irq_n,
	// lock status pin
	output logic lock_indicator,
	// configuration from the register file
	input wire logic spi_4wire,
	input wire logic manual_sel,
	input wire logic [1:0] auto_in_sel,
	input wire logic irq_clear,
	// serial engine side
	input wire logic ser_dout,
	input wire logic ser_drive,
	output cgcp_ser_t ser_pins,
	output cgcp_mode_t ser_mode,
	// core status and control
	input wire logic [CGCP_STAT_W-1:0] status_in,
	input wire logic pll_locked,
	output logic core_reset,
	output logic low_power,
	output logic clk_out_en,
	output logic [CGCP_N_OUT-1:0] div_reset,
	output logic [CGCP_N_IN-1:0] clk_in_sel
);
	// ==========================================================
	// pin synchronisers
	cgcp_pins_t meta_q, sync_q;
	logic int_rst;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			meta_q <= CGCP_PINS_RST;
			sync_q <= CGCP_PINS_RST;
		end else begin
			meta_q <= pins_in;
			sync_q <= meta_q;
		end
	end

	assign int_rst = !resetn || !sync_q.hard_reset_n;

	// ==========================================================
	// serial interface mode and pin mux
	cgcp_mode_t mode_q, mode_d;
	cgcp_ser_t ser_q, ser_d;
	cgcp_drv_t sdio_q, sdio_d, sdo_q, sdo_d;

	always_comb begin
		if (sync_q.if_sel == CGCP_IF_I2C) begin
			mode_d = CGCP_MODE_I2C;
		end else if (spi_4wire) begin
			mode_d = CGCP_MODE_SPI4;
		end else begin
			mode_d = CGCP_MODE_SPI3;
		end
		ser_d.sclk = sync_q.sclk;
		ser_d.din = sync_q.sdio;
		ser_d.cs_n = 1'b1;
		ser_d.addr = 2'h0;
		sdio_d = CGCP_DRV_OFF;
		sdo_d = CGCP_DRV_OFF;
		case (mode_q)
			CGCP_MODE_I2C: begin
				ser_d.addr = {sync_q.addr1, sync_q.addr0_cs_n};
				sdio_d.out = 1'b0;
				sdio_d.oe = ser_drive && !ser_dout;
			end
			CGCP_MODE_SPI3: begin
				ser_d.cs_n = sync_q.addr0_cs_n;
				sdio_d.out = ser_dout;
				sdio_d.oe = ser_drive && !sync_q.addr0_cs_n;
			end
			CGCP_MODE_SPI4: begin
				ser_d.cs_n = sync_q.addr0_cs_n;
				sdo_d.out = ser_dout;
				sdo_d.oe = ser_drive && !sync_q.addr0_cs_n;
			end
			default: begin
				ser_d = CGCP_SER_RST;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (int_rst) begin
			mode_q <= CGCP_MODE_I2C;
			ser_q <= CGCP_SER_RST;
			sdio_q <= CGCP_DRV_OFF;
			sdo_q <= CGCP_DRV_OFF;
		end else begin
			mode_q <= mode_d;
			ser_q <= ser_d;
			sdio_q <= sdio_d;
			sdo_q <= sdo_d;
		end
	end

	assign ser_mode = mode_q;
	assign ser_pins = ser_q;
	assign sdio_drv = sdio_q;
	assign addr1_sdo_drv = sdo_q;

	// ==========================================================
	// status change interrupt
	logic [CGCP_STAT_W-1:0] stat_q, stat_d;
	logic pend_q, pend_d, chg;

	always_comb begin
		stat_d = status_in;
		chg = (status_in != stat_q);
		// change sets, set wins over clear
		pend_d = chg || (pend_q && !irq_clear);
	end

	always_ff @(posedge mclk) begin
		if (int_rst) begin
			stat_q <= '0;
			pend_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			pend_q <= pend_d;
		end
	end

	assign status_change_irq_n = '{out: 1'b0, oe: pend_q};

	// ==========================================================
	// device control outputs
	logic lock_q, lock_d, lp_q, lp_d, en_q, en_d;
	logic [CGCP_N_OUT-1:0] div_q, div_d;
	logic [CGCP_N_IN-1:0] sel_q, sel_d;
	logic [1:0] sel_idx;

	always_comb begin
		lock_d = pll_locked;
		lp_d = !sync_q.low_power_n;
		en_d = !sync_q.out_dis;
		div_d = sync_q.realign_n ? '0 : '1;
		sel_idx = manual_sel ? sync_q.in_sel : auto_in_sel;
		sel_d = '0;
		sel_d[sel_idx] = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (int_rst) begin
			lock_q <= 1'b0;
			lp_q <= 1'b0;
			en_q <= 1'b0;
			div_q <= '1;
			sel_q <= {{(CGCP_N_IN-1){1'b0}}, 1'b1};
		end else begin
			lock_q <= lock_d;
			lp_q <= lp_d;
			en_q <= en_d;
			div_q <= div_d;
			sel_q <= sel_d;
		end
	end

	assign lock_indicator = lock_q;
	assign low_power = lp_q;
	assign clk_out_en = en_q;
	assign div_reset = div_q;
	assign clk_in_sel = sel_q;
	assign core_reset = int_rst;

	// ==========================================================
	// assertions
	property p_mode_i2c;
		@(posedge mclk) disable iff (!resetn)
		!int_rst && sync_q.if_sel |=> ser_mode == CGCP_MODE_I2C;
	endproperty
	a_mode_i2c: assert property (p_mode_i2c) else $error("I2C mode not taken");

	property p_spi4_sdi;
		@(posedge mclk) disable iff (!resetn)
		ser_mode == CGCP_MODE_SPI4 |=> !sdio_drv.oe;
	endproperty
	a_spi4_sdi: assert property (p_spi4_sdi) else $error("data pin driven in 4-wire");

	property p_i2c_addr1;
		@(posedge mclk) disable iff (!resetn)
		ser_mode == CGCP_MODE_I2C |=> !addr1_sdo_drv.oe;
	endproperty
	a_i2c_addr1: assert property (p_i2c_addr1) else $error("address pin driven in I2C");

	property p_cs_track;
		@(posedge mclk) disable iff (int_rst)
		ser_mode == CGCP_MODE_SPI3 && pins_in.addr0_cs_n ##1 !int_rst
			##1 ser_mode == CGCP_MODE_SPI3 |=> ser_pins.cs_n;
	endproperty
	a_cs_track: assert property (p_cs_track) else $error("select not followed");

	property p_irq_set;
		@(posedge mclk) disable iff (!resetn)
		!int_rst && status_in != $past(status_in) && !$past(int_rst)
			|=> status_change_irq_n.oe && !status_change_irq_n.out;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("status change lost");

	property p_low_power;
		@(posedge mclk) disable iff (!resetn)
		!int_rst && !sync_q.low_power_n |=> low_power;
	endproperty
	a_low_power: assert property (p_low_power) else $error("low power missed");

	property p_rst_off;
		@(posedge mclk) disable iff (!resetn)
		int_rst |=> !clk_out_en && div_reset == '1 && !status_change_irq_n.oe;
	endproperty
	a_rst_off: assert property (p_rst_off) else $error("reset state wrong");

	property p_out_dis;
		@(posedge mclk) disable iff (!resetn)
		sync_q.out_dis |=> !clk_out_en;
	endproperty
	a_out_dis: assert property (p_out_dis) else $error("outputs not disabled");

	property p_lock;
		@(posedge mclk) disable iff (!resetn)
		!int_rst |=> lock_indicator == $past(pll_locked);
	endproperty
	a_lock: assert property (p_lock) else $error("lock output wrong");

	property p_realign;
		@(posedge mclk) disable iff (!resetn)
		!pins_in.realign_n ##1 !pins_in.realign_n ##1 !pins_in.realign_n |=> div_reset == '1;
	endproperty
	a_realign: assert property (p_realign) else $error("dividers not reset");

	property p_release;
		@(posedge mclk) disable iff (!resetn)
		!int_rst && sync_q.realign_n |=> div_reset == '0;
	endproperty
	a_release: assert property (p_release) else $error("dividers not released");

	property p_sel;
		@(posedge mclk) disable iff (!resetn)
		!int_rst && manual_sel |=> clk_in_sel == (4'h1 << $past(sync_q.in_sel));
	endproperty
	a_sel: assert property (p_sel) else $error("input select wrong");

	c_spi4: cover property (@(posedge mclk) ser_mode == CGCP_MODE_SPI4 && addr1_sdo_drv.oe);
	c_irq: cover property (@(posedge mclk) status_change_irq_n.oe ##1 irq_clear);
	c_realign: cover property (@(posedge mclk) div_reset == '1 ##1 div_reset == '0);
	c_sel3: cover property (@(posedge mclk) manual_sel && clk_in_sel == 4'h8);
endmodule

// File: bench/cgcp_host.sv
// host controller model driving the serial pins
`timescale 1ns/1ps
module cgcp_host (
	// clock
	input wire logic mclk,
	// frame request from the bench
	input wire logic frame,
	// serial pins from the host
	output logic sclk,
	output logic cs_n,
	output logic sdo,
	output logic sdo_en
);
	logic f;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdo = 1'b0;
		sdo_en = 1'b0;
	end
	// ==========
	// frames
	always @(posedge mclk) begin
		f = frame;
		#1;
		cs_n = !f;
		sclk = f ? !sclk : 1'b1;
		// data driven or released at random
		sdo_en = f && $urandom_range(1);
		sdo = 1'($urandom_range(1));
	end
endmodule

// File: bench/cgcp_pins_bench.sv
// self-checking bench of the control pin logic
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("[FAIL] %s exp %h got %h", n, e, a); \
	end \
end
module cgcp_pins_bench
	import cgcp_pkg::*;
;
	logic mclk, resetn, spi_4wire, manual_sel, irq_clear, ser_dout, ser_drive, pll_locked;
	logic frame, h_sclk, h_cs_n, h_sdo, h_en, sdio_w, lock_indicator, core_reset;
	logic low_power, clk_out_en, chg, skip;
	logic [1:0] auto_in_sel;
	logic [CGCP_STAT_W-1:0] status_in;
	logic [CGCP_N_IN-1:0] clk_in_sel;
	logic [CGCP_N_OUT-1:0] div_reset;
	cgcp_pins_t p, pins_in;
	cgcp_pins_t hist [4];
	cgcp_drv_t sdio_drv, a1_drv, irq_drv;
	cgcp_ser_t ser_pins;
	cgcp_mode_t ser_mode;
	int bad_count = 0;
	int num_checks = 0;
	// ==========
	// pins and parties
	assign sdio_w = sdio_drv.oe ? sdio_drv.out : (h_en ? h_sdo : 1'b1);
	always_comb begin
		pins_in = p;
		pins_in.sdio = sdio_w;
		pins_in.addr1 = a1_drv.oe ? a1_drv.out : p.addr1;
		if (frame) begin
			pins_in.sclk = h_sclk;
			pins_in.addr0_cs_n = h_cs_n;
		end
	end
	cgcp_host u_cgcp_host (.mclk(mclk), .frame(frame), .sclk(h_sclk), .cs_n(h_cs_n),
		.sdo(h_sdo), .sdo_en(h_en));
	cgcp_pins u_cgcp_pins (.mclk(mclk), .resetn(resetn), .pins_in(pins_in),
		.sdio_drv(sdio_drv), .addr1_sdo_drv(a1_drv), .status_change_irq_n(irq_drv),
		.lock_indicator(lock_indicator), .spi_4wire(spi_4wire), .manual_sel(manual_sel),
		.auto_in_sel(auto_in_sel), .irq_clear(irq_clear), .ser_dout(ser_dout),
		.ser_drive(ser_drive), .ser_pins(ser_pins), .ser_mode(ser_mode),
		.status_in(status_in), .pll_locked(pll_locked), .core_reset(core_reset),
		.low_power(low_power), .clk_out_en(clk_out_en), .div_reset(div_reset),
		.clk_in_sel(clk_in_sel));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// ==========
	// tasks
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic check_all();
		logic i, h, s, so, ao;
		cgcp_mode_t m;
		i = p.if_sel;
		h = p.hard_reset_n;
		s = !i && !p.addr0_cs_n;
		m = i ? CGCP_MODE_I2C : (spi_4wire ? CGCP_MODE_SPI4 : CGCP_MODE_SPI3);
		so = h && (i ? ser_drive && !ser_dout : m == CGCP_MODE_SPI3 && s && ser_drive);
		ao = h && m == CGCP_MODE_SPI4 && s && ser_drive;
		`CHK("mode", h ? m : CGCP_MODE_I2C, ser_mode)
		`CHK("sdio_oe", so, sdio_drv.oe)
		`CHK("sdio_out", so && !i && ser_dout, so && sdio_drv.out)
		`CHK("din", !so || (!i && ser_dout), ser_pins.din)
		`CHK("sdo_oe", ao, a1_drv.oe)
		`CHK("sdo_out", ao && ser_dout, ao && a1_drv.out)
		`CHK("addr", (h && i) ? {p.addr1, p.addr0_cs_n} : 2'h0, ser_pins.addr)
		`CHK("cs_n", i || !h || p.addr0_cs_n, ser_pins.cs_n)
		`CHK("sclk", 1'b1, ser_pins.sclk)
		if (!skip) `CHK("irq", h && chg, irq_drv.oe)
		`CHK("low_power", h && !p.low_power_n, low_power)
		`CHK("core_reset", !h, core_reset)
		`CHK("lock", h && pll_locked, lock_indicator)
		`CHK("in_sel", h ? 4'h1 << (manual_sel ? p.in_sel : auto_in_sel) : 4'h1, clk_in_sel)
		if (p.low_power_n) begin
			`CHK("out_en", h && !p.out_dis, clk_out_en)
			`CHK("div", (h && p.realign_n) ? 12'h0 : 12'hfff, div_reset)
		end
	endtask
	task automatic step(input logic hr);
		logic [CGCP_STAT_W-1:0] s0;
		s0 = status_in;
		p = 11'($urandom);
		p.sclk = 1'b1;
		p.hard_reset_n = hr;
		{spi_4wire, manual_sel, auto_in_sel, pll_locked, ser_dout, ser_drive, status_in} = 11'($urandom);
		chg = status_in !== s0;
		tick(7);
		check_all();
		irq_clear = 1'b1;
		tick(1);
		irq_clear = 1'b0;
		tick(1);
		`CHK("irq_clear", 1'b0, irq_drv.oe)
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========
	// frame watch, outputs lag the pins by three edges
	always @(posedge mclk) begin
		#2;
		for (int k = 3; k > 0; k--) begin
			hist[k] = hist[k-1];
		end
		hist[0] = pins_in;
		if (frame && hist[3].addr0_cs_n === 1'b0) begin
			`CHK("f_sclk", hist[3].sclk, ser_pins.sclk)
			`CHK("f_din", hist[3].sdio, ser_pins.din)
			`CHK("f_cs_n", 1'b0, ser_pins.cs_n)
		end
	end
	// ==========
	// tests
	initial begin
		p = CGCP_PINS_RST;
		{spi_4wire, manual_sel, auto_in_sel, pll_locked, ser_dout, ser_drive, status_in} = '0;
		{frame, irq_clear, resetn, chg, skip} = '0;
		void'($urandom(32'h49ff));
		tick(3);
		resetn = 1'b1;
		tick(4);
		check_all();
		repeat (60) step(1'b1);
		$display("random pin test done");
		step(1'b0);
		skip = 1'b1;
		step(1'b1);
		skip = 1'b0;
		$display("hard reset test done");
		p = CGCP_PINS_RST;
		p.if_sel = 1'b0;
		{spi_4wire, ser_drive} = '0;
		tick(5);
		frame = 1'b1;
		tick(40);
		frame = 1'b0;
		tick(2);
		$display("spi frame test done");
		finish_test();
	end
	initial begin
		#16000;
		bad_count++;
		finish_test();
	end
endmodule
